/* File: core/port_reset_control.v */
// Purpose: Secondary bus reset control and downstream reset outputs.
// Assumes: Link-up, hot reset and power-good arrive as pins; synchronised.
// Notes: Register port reads return data one cycle after the strobe.
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "port_reset_defs.vh"
module port_reset_control (
	input  wire                       core_clk,
	input  wire                       reset,
	input  wire [3:0]                 reg_addr,
	input  wire [31:0]                reg_wdata,
	input  wire                       reg_wr,
	input  wire                       reg_rd,
	output reg  [31:0]                reg_rdata_q,
	input  wire                       smbus_rd,
	input  wire [3:0]                 smbus_addr,
	output reg  [31:0]                smbus_rdata_q,
	input  wire                       hot_reset_in,
	input  wire [`NUM_DS_PORTS-1:0]   link_up_in,
	input  wire [`NUM_DS_PORTS-1:0]   slot_power_good_n,
	output reg  [`NUM_DS_PORTS-1:0]   ts1_hot_reset_q,
	output reg  [`NUM_DS_PORTS-1:0]   ds_reg_reset_q,
	output reg  [`NUM_DS_PORTS-1:0]   queue_flush_q,
	output reg  [`NUM_DS_PORTS-1:0]   ds_logic_reset_q,
	output reg  [`NUM_DS_PORTS-1:0]   ur_secondary_q,
	output reg                        up_link_hold_q,
	output reg  [`NUM_DS_PORTS-1:0]   slot_power_enable_out,
	output reg  [`NUM_DS_PORTS-1:0]   port_reset_out_n,
	output reg  [`NUM_DS_PORTS-1:0]   port_reset_oe
);
	localparam N = `NUM_DS_PORTS;
	reg [N-1:0]          link_s1_q;
	reg [N-1:0]          link_s2_q;
	reg [N-1:0]          pg_s1_q;
	reg [N-1:0]          pg_s2_q;
	reg                  hot_s1_q;
	reg                  hot_s2_q;
	reg                  up_secondary_reset_request_q;
	reg [N-1:0]          ds_secondary_reset_request_q;
	reg [1:0]            reset_output_mode_q;
	reg [N-1:0]          slot_power_off_ctl_q;
	reg [`DELAY_W-1:0]   power_to_reset_delay_q;
	reg [`DELAY_W-1:0]   reset_to_power_delay_q;
	reg [N-1:0]          pin_enable_q;
	reg [N-1:0]          up_ts1_sent_q;
	reg [N-1:0]          ds_ts1_sent_q;
	wire [N-1:0]         power_en;
	wire [N-1:0]         rst_asserted;
	wire [N-1:0]         port_held;
	reg  [31:0]          rd_mux;
	reg  [31:0]          smb_mux;
	assign port_held = {N{up_secondary_reset_request_q}} | ds_secondary_reset_request_q;
	// Pin inputs pass two flops before any logic looks at them.
	always @(posedge core_clk) begin
		if (reset) begin
			link_s1_q <= {N{1'b0}};
			link_s2_q <= {N{1'b0}};
			pg_s1_q   <= {N{1'b1}};
			pg_s2_q   <= {N{1'b1}};
			hot_s1_q  <= 1'b0;
			hot_s2_q  <= 1'b0;
		end else begin
			link_s1_q <= link_up_in;
			link_s2_q <= link_s1_q;
			pg_s1_q   <= slot_power_good_n;
			pg_s2_q   <= pg_s1_q;
			hot_s1_q  <= hot_reset_in;
			hot_s2_q  <= hot_s1_q;
		end
	end
	// Register writes. Slot bits take writes even under hold; only the SMBus read shows them at default.
	always @(posedge core_clk) begin
		if (reset) begin
			up_secondary_reset_request_q            <= 1'b0;
			ds_secondary_reset_request_q            <= {N{1'b0}};
			reset_output_mode_q    <= `MODE_PWR_EN;
			slot_power_off_ctl_q   <= `SLOT_CTL_RESET;
			power_to_reset_delay_q <= `POWER_TO_RESET_DELAY_RESET;
			reset_to_power_delay_q <= `RESET_TO_POWER_DELAY_RESET;
			pin_enable_q           <= {N{1'b0}};
		end else if (reg_wr) begin
			if (reg_addr == `REG_UP_BRIDGE_CTL) begin
				up_secondary_reset_request_q <= reg_wdata[`UP_SECONDARY_RESET_REQUEST_BIT];
			end else if (reg_addr == `REG_HOTPLUG_CFG) begin
				reset_output_mode_q <= reg_wdata[1:0];
			end else if (reg_addr == `REG_SLOT_CTL) begin
				slot_power_off_ctl_q <= reg_wdata[N-1:0];
			end else if (reg_addr == `REG_PORT_BRIDGE_CTL) begin
				ds_secondary_reset_request_q <= reg_wdata[N-1:0];
			end else if (reg_addr == `REG_DELAYS) begin
				power_to_reset_delay_q <= reg_wdata[15:0];
				reset_to_power_delay_q <= reg_wdata[31:16];
			end else if (reg_addr == `REG_PIN_ENABLE) begin
				pin_enable_q <= reg_wdata[N-1:0];
			end
		end
	end
	always @* begin
		rd_mux = 32'h00000000;
		if (reg_addr == `REG_UP_BRIDGE_CTL) begin
			rd_mux[`UP_SECONDARY_RESET_REQUEST_BIT] = up_secondary_reset_request_q;
		end else if (reg_addr == `REG_HOTPLUG_CFG) begin
			rd_mux[1:0] = reset_output_mode_q;
		end else if (reg_addr == `REG_SLOT_CTL) begin
			rd_mux[N-1:0] = slot_power_off_ctl_q;
		end else if (reg_addr == `REG_PORT_BRIDGE_CTL) begin
			rd_mux[N-1:0] = ds_secondary_reset_request_q;
		end else if (reg_addr == `REG_STATUS) begin
			rd_mux = {16'h0000, rst_asserted, power_en, link_s2_q, port_held};
		end else if (reg_addr == `REG_DELAYS) begin
			rd_mux = {reset_to_power_delay_q, power_to_reset_delay_q};
		end else if (reg_addr == `REG_PIN_ENABLE) begin
			rd_mux[N-1:0] = pin_enable_q;
		end
	end
	// The slave SMBus decodes its own address, independent of the
	// register port. The slot control field reads as its default under upstream hold.
	always @* begin
		smb_mux = 32'h00000000;
		if (smbus_addr == `REG_UP_BRIDGE_CTL) begin
			smb_mux[`UP_SECONDARY_RESET_REQUEST_BIT] = up_secondary_reset_request_q;
		end else if (smbus_addr == `REG_HOTPLUG_CFG) begin
			smb_mux[1:0] = reset_output_mode_q;
		end else if (smbus_addr == `REG_SLOT_CTL) begin
			if (up_secondary_reset_request_q)
				smb_mux[N-1:0] = `SLOT_CTL_RESET;
			else
				smb_mux[N-1:0] = slot_power_off_ctl_q;
		end else if (smbus_addr == `REG_PORT_BRIDGE_CTL) begin
			smb_mux[N-1:0] = ds_secondary_reset_request_q;
		end else if (smbus_addr == `REG_STATUS) begin
			smb_mux = {16'h0000, rst_asserted, power_en, link_s2_q,
				port_held};
		end else if (smbus_addr == `REG_DELAYS) begin
			smb_mux = {reset_to_power_delay_q, power_to_reset_delay_q};
		end else if (smbus_addr == `REG_PIN_ENABLE) begin
			smb_mux[N-1:0] = pin_enable_q;
		end
	end
	always @(posedge core_clk) begin
		if (reset) begin
			reg_rdata_q   <= 32'h00000000;
			smbus_rdata_q <= 32'h00000000;
		end else begin
			reg_rdata_q   <= reg_rd ? rd_mux : 32'h00000000;
			smbus_rdata_q <= smbus_rd ? smb_mux : 32'h00000000;
		end
	end
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : g_port
			wire held_hot = hot_s2_q | port_held[g];
			slot_sequencer u_seq (
				.core_clk       (core_clk),
				.reset          (reset),
				.mode           (reset_output_mode_q),
				.power_off_req  (slot_power_off_ctl_q[g] | up_secondary_reset_request_q),
				.power_good     (!pg_s2_q[g]),
				.hot_cond       (held_hot),
				.power_to_reset_delay        (power_to_reset_delay_q),
				.reset_to_power_delay        (reset_to_power_delay_q),
				.power_en_q     (power_en[g]),
				.rst_asserted_q (rst_asserted[g])
			);
			always @(posedge core_clk) begin
				if (reset) begin
					ts1_hot_reset_q[g]       <= 1'b0;
					up_ts1_sent_q[g]         <= 1'b0;
					ds_ts1_sent_q[g]         <= 1'b0;
					ds_reg_reset_q[g]        <= 1'b0;
					queue_flush_q[g]         <= 1'b0;
					ds_logic_reset_q[g]      <= 1'b0;
					ur_secondary_q[g]        <= 1'b0;
					slot_power_enable_out[g] <= 1'b0;
					port_reset_out_n[g]      <= 1'b0;
					port_reset_oe[g]         <= 1'b0;
				end else begin
					up_ts1_sent_q[g] <= up_secondary_reset_request_q;
					ds_ts1_sent_q[g] <= ds_secondary_reset_request_q[g];
					// TS1 is sent once per reset entry while the link is up.
					ts1_hot_reset_q[g] <= link_s2_q[g] &
						((up_secondary_reset_request_q & !up_ts1_sent_q[g]) |
						(ds_secondary_reset_request_q[g] & !ds_ts1_sent_q[g]));
					ds_reg_reset_q[g]   <= up_secondary_reset_request_q;
					queue_flush_q[g]    <= port_held[g];
					ds_logic_reset_q[g] <= port_held[g];
					ur_secondary_q[g]   <= port_held[g];
					slot_power_enable_out[g] <= power_en[g];
					port_reset_out_n[g]      <= !rst_asserted[g];
					port_reset_oe[g]         <= pin_enable_q[g];
				end
			end
		end
	endgenerate
	// Upstream port is never held by any secondary bus reset.
	always @(posedge core_clk) begin
		if (reset)
			up_link_hold_q <= 1'b0;
		else
			up_link_hold_q <= 1'b0;
	end
endmodule // port_reset_control

/* File: common/port_reset_defs.vh */
// Purpose: Constants for the downstream port reset control block.
// Assumes: Core clock of 50 MHz; registers reached over a plain strobe port.
// Notes: Offsets are word indices on the register port.
`ifndef PORT_RESET_DEFS_VH
`define PORT_RESET_DEFS_VH
`define NUM_DS_PORTS         4
`define CLK_MHZ              50
`define MIN_PULSE_US         200
`define MIN_PULSE_CYC        (`MIN_PULSE_US * `CLK_MHZ)
// Pulse counter load value, one less than the minimum pulse in cycles.
`define MIN_PULSE_LOAD       14'h270F
`define REG_UP_BRIDGE_CTL    4'h0
`define REG_HOTPLUG_CFG      4'h1
`define REG_SLOT_CTL         4'h2
`define REG_PORT_BRIDGE_CTL  4'h3
`define REG_STATUS           4'h4
`define REG_DELAYS           4'h5
`define REG_PIN_ENABLE       4'h6
`define UP_SECONDARY_RESET_REQUEST_BIT        6
`define MODE_PWR_EN          2'h0
`define MODE_PWR_GOOD        2'h1
`define MODE_HOT_RESET       2'h2
`define DELAY_W              16
`define POWER_TO_RESET_DELAY_RESET        16'h0064
`define RESET_TO_POWER_DELAY_RESET        16'h0064
`define SLOT_CTL_RESET       4'hF
`endif

/* File: core/slot_sequencer.v */
// Purpose: Per-port slot power and reset output sequencer.
// Assumes: Power-good input already synchronised, active high here.
// Notes: Delays count core clock cycles.
`timescale 1ns/1ps
`include "port_reset_defs.vh"
module slot_sequencer (
	input  wire                  core_clk,
	input  wire                  reset,
	input  wire [1:0]            mode,
	input  wire                  power_off_req,
	input  wire                  power_good,
	input  wire                  hot_cond,
	input  wire [`DELAY_W-1:0]   power_to_reset_delay,
	input  wire [`DELAY_W-1:0]   reset_to_power_delay,
	output reg                   power_en_q,
	output reg                   rst_asserted_q
);
	localparam S_OFF     = 3'h0;
	localparam S_PWR_UP  = 3'h1;
	localparam S_RUN     = 3'h2;
	localparam S_PWR_DN  = 3'h3;
	localparam S_HOLD    = 3'h4;
	reg [2:0]          state_q;
	reg [`DELAY_W-1:0] delay_q;
	reg [13:0]         pulse_q;
	wire pulse_done = (pulse_q == 14'h0000);
	wire hot_mode = (mode == `MODE_HOT_RESET);
	always @(posedge core_clk) begin
		if (reset) begin
			state_q        <= S_OFF;
			delay_q        <= {`DELAY_W{1'b0}};
			pulse_q        <= `MIN_PULSE_LOAD;
			power_en_q     <= 1'b0;
			rst_asserted_q <= 1'b1;
		end else begin
			if (!pulse_done)
				pulse_q <= pulse_q - 14'h0001;
			if (hot_mode) begin
				// Power still follows power_off_req (slot control bit or upstream hold), without sequencing.
				power_en_q <= !power_off_req;
				// The state follows the pin, so that a later mode change
				// does not glitch the reset of a slot that is running.
				state_q    <= S_OFF;
				if (hot_cond) begin
					if (!rst_asserted_q)
						pulse_q <= `MIN_PULSE_LOAD;
					rst_asserted_q <= 1'b1;
				end else if (pulse_done) begin
					rst_asserted_q <= 1'b0;
					if (!power_off_req)
						state_q <= S_RUN;
				end
			end else begin
				case (state_q)
				S_OFF: begin
					rst_asserted_q <= 1'b1;
					if (!rst_asserted_q)
						pulse_q <= `MIN_PULSE_LOAD;
					power_en_q     <= 1'b0;
					if (!power_off_req) begin
						power_en_q <= 1'b1;
						delay_q    <= power_to_reset_delay;
						state_q    <= S_PWR_UP;
					end
				end
				S_PWR_UP: begin
					if (power_off_req) begin
						delay_q <= reset_to_power_delay;
						state_q <= S_PWR_DN;
					end else if (mode == `MODE_PWR_GOOD && !power_good) begin
						delay_q <= power_to_reset_delay;
					end else if (delay_q != {`DELAY_W{1'b0}}) begin
						delay_q <= delay_q - 1'b1;
					end else if (pulse_done) begin
						rst_asserted_q <= 1'b0;
						state_q        <= S_RUN;
					end
				end
				S_RUN: begin
					if (power_off_req) begin
						rst_asserted_q <= 1'b1;
						pulse_q        <= `MIN_PULSE_LOAD;
						delay_q        <= reset_to_power_delay;
						state_q        <= S_PWR_DN;
					end else if (mode == `MODE_PWR_GOOD && !power_good) begin
						rst_asserted_q <= 1'b1;
						pulse_q        <= `MIN_PULSE_LOAD;
						delay_q        <= power_to_reset_delay;
						state_q        <= S_PWR_UP;
					end
				end
				S_PWR_DN: begin
					rst_asserted_q <= 1'b1;
					if (delay_q != {`DELAY_W{1'b0}}) begin
						delay_q <= delay_q - 1'b1;
					end else begin
						power_en_q <= 1'b0;
						state_q    <= S_OFF;
					end
				end
				default: state_q <= S_OFF;
				endcase
			end
		end
	end
endmodule // slot_sequencer

/* File: verification/port_reset_control_asserts.sv */
// Purpose: Port-level checks for the port reset controller.
// Assumes: Only the top module's ports are visible.
// Notes: Port 0 stands in for all ports in the reset pulse length and power order checks.
`timescale 1ns/1ps
`include "port_reset_defs.vh"
module port_reset_control_asserts (
	input wire logic                     core_clk,
	input wire logic                     reset,
	input wire logic                     reg_rd,
	input wire logic [31:0]              reg_rdata_q,
	input wire logic [`NUM_DS_PORTS-1:0] ts1_hot_reset_q,
	input wire logic [`NUM_DS_PORTS-1:0] ds_reg_reset_q,
	input wire logic [`NUM_DS_PORTS-1:0] queue_flush_q,
	input wire logic [`NUM_DS_PORTS-1:0] ds_logic_reset_q,
	input wire logic [`NUM_DS_PORTS-1:0] ur_secondary_q,
	input wire logic                     up_link_hold_q,
	input wire logic [`NUM_DS_PORTS-1:0] slot_power_enable_out,
	input wire logic [`NUM_DS_PORTS-1:0] port_reset_out_n,
	input wire logic [`NUM_DS_PORTS-1:0] port_reset_oe
);
	logic [15:0] low_q;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// Saturates so a long hold cannot wrap into a short one.
	always @(posedge core_clk) begin
		if (reset || port_reset_out_n[0])
			low_q <= 16'h0000;
		else if (low_q != 16'hFFFF)
			low_q <= low_q + 16'h0001;
	end
	AST_READ_IDLE: assert property (!$past(reg_rd) |-> reg_rdata_q == 0)
		else $error("read data outside read slot");
	AST_OE_RESET: assert property ($fell(reset) |-> port_reset_oe == 0)
		else $error("reset pins driven after reset");
	AST_MIN_PULSE: assert property ($rose(port_reset_out_n[0])
		|-> low_q >= `MIN_PULSE_CYC - 2) else $error("reset pulse too short");
	AST_TS1_PULSE: assert property (ts1_hot_reset_q != 0
		|=> ts1_hot_reset_q == 0) else $error("hot reset pulse too long");
	AST_UP_HOLDS: assert property ((&ds_reg_reset_q) |-> ##[0:3]
		((&queue_flush_q) && (&ds_logic_reset_q))) else $error("hold missing");
	AST_UR_FLUSH: assert property (ur_secondary_q == queue_flush_q)
		else $error("unsupported request set differs from flush set");
	AST_UP_LINK: assert property (up_link_hold_q == 1'b0)
		else $error("upstream link disturbed");
	AST_PWR_FIRST: assert property ($rose(port_reset_out_n[0])
		|-> slot_power_enable_out[0]) else $error("reset released unpowered");
	AST_RST_FIRST: assert property ($fell(slot_power_enable_out[0])
		|-> !port_reset_out_n[0]) else $error("power dropped before reset");
endmodule // port_reset_control_asserts
bind port_reset_control port_reset_control_asserts chk_u (
	.core_clk(core_clk), .reset(reset), .reg_rd(reg_rd),
	.reg_rdata_q(reg_rdata_q), .ts1_hot_reset_q(ts1_hot_reset_q),
	.ds_reg_reset_q(ds_reg_reset_q), .queue_flush_q(queue_flush_q),
	.ds_logic_reset_q(ds_logic_reset_q), .ur_secondary_q(ur_secondary_q),
	.up_link_hold_q(up_link_hold_q), .port_reset_oe(port_reset_oe),
	.slot_power_enable_out(slot_power_enable_out),
	.port_reset_out_n(port_reset_out_n));

/* File: verification/slot_partner.sv */
// Purpose: Slot power switch with power-good and pulled-down reset pins.
// Assumes: Power good settles a fixed number of cycles after enable.
// Notes: A fault input lets the bench remove power good on command.
`timescale 1ns/1ps
module slot_partner #(
	parameter int PG_DLY = 8
) (
	input  wire logic       core_clk,
	input  wire logic [3:0] power_en,
	input  wire logic [3:0] fault,
	input  wire logic [3:0] reset_out_n,
	input  wire logic [3:0] oe,
	output logic      [3:0] power_good_n,
	output logic      [3:0] pin
);
	logic [7:0] cnt [4];
	always @(posedge core_clk) begin
		for (int i = 0; i < 4; i++) begin
			if (!power_en[i] || fault[i])
				cnt[i] <= 8'h00;
			else if (cnt[i] < PG_DLY)
				cnt[i] <= cnt[i] + 8'h01;
		end
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			power_good_n[i] = !(cnt[i] == PG_DLY && !fault[i]);
			pin[i] = oe[i] ? reset_out_n[i] : 1'b0;
		end
	end
endmodule // slot_partner

/* File: verification/port_reset_control_test.sv */
// Purpose: Directed bench for the port reset controller.
// Assumes: Delays are shortened through the delay register.
// Notes: Pin levels are read through the partner's pull-downs.
`timescale 1ns/1ps
`include "port_reset_defs.vh"
module port_reset_control_test;
	logic        core_clk, reset, reg_wr, reg_rd, smbus_rd, hot_reset_in;
	logic [3:0]  reg_addr, smbus_addr, link_up_in, fault, pg_n, ts1, flush;
	logic [3:0]  ur, pen, rst_n, oe, pin, seen, dsreg, lrst;
	logic [31:0] reg_wdata, rdata, sdata;
	int          n_fail, n_checks, n;
	port_reset_control dut_u (.core_clk(core_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_q(rdata), .smbus_rd(smbus_rd),
		.smbus_addr(smbus_addr), .smbus_rdata_q(sdata),
		.hot_reset_in(hot_reset_in), .link_up_in(link_up_in),
		.slot_power_good_n(pg_n), .ts1_hot_reset_q(ts1),
		.ds_reg_reset_q(dsreg), .queue_flush_q(flush),
		.ds_logic_reset_q(lrst), .ur_secondary_q(ur), .up_link_hold_q(),
		.slot_power_enable_out(pen), .port_reset_out_n(rst_n),
		.port_reset_oe(oe));
	slot_partner part_u (.core_clk(core_clk), .power_en(pen), .fault(fault),
		.reset_out_n(rst_n), .oe(oe), .power_good_n(pg_n), .pin(pin));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task test_done;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 cmp(rdata, exp);
	endtask
	task smb_rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		smbus_addr <= a;
		smbus_rd <= 1'b1;
		@(posedge core_clk);
		smbus_rd <= 1'b0;
		#1 cmp(sdata, exp);
	endtask
	// A bound that runs out counts as a failure and ends the run.
	task wait_pin(input int p, input logic lvl, input int lim);
		n = 0;
		while (pin[p] !== lvl) begin
			@(posedge core_clk);
			#1 n++;
			if (n > lim) begin
				n_fail++;
				test_done;
			end
		end
	endtask
	task ts1_seen;
		seen = 4'h0;
		repeat (8) begin
			@(posedge core_clk);
			#1 seen = seen | ts1;
		end
	endtask
	initial begin
		{reset, reg_wr, reg_rd, smbus_rd, hot_reset_in} = 5'h10;
		{reg_addr, smbus_addr, fault} = 12'h000;
		reg_wdata = 32'h0;
		link_up_in = 4'h5;
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		rd(4'h2, 32'h0000000F);
		rd(4'h5, 32'h00640064);
		rd(4'h6, 32'h0);
		rd(4'h7, 32'h0);
		cmp(oe, 4'h0);
		wr(4'h5, 32'h00040006);
		wr(4'h6, 32'h0000000F);
		rd(4'h5, 32'h00040006);
		wr(4'h2, 32'h0000000E);
		wait_pin(0, 1'b1, 12000);
		cmp({pen, pin}, 8'h11);
		wr(4'h2, 32'h0000000F);
		wait_pin(0, 1'b0, 4);
		repeat (12) @(posedge core_clk);
		cmp(pen, 4'h0);
		wr(4'h2, 32'h00000007);
		wr(4'h0, 32'h00000040);
		ts1_seen;
		cmp(seen, 4'h5);
		cmp({dsreg, flush, lrst}, 12'hFFF);
		smb_rd(4'h2, 32'h0000000F);
		smb_rd(4'h5, 32'h00040006);
		wr(4'h0, 32'h0);
		repeat (6) @(posedge core_clk);
		cmp(flush, 4'h0);
		wr(4'h3, 32'h00000006);
		ts1_seen;
		cmp({seen, flush, ur}, 12'h466);
		rd(4'h3, 32'h00000006);
		wr(4'h3, 32'h0);
		wr(4'h1, 32'h00000002);
		rd(4'h1, 32'h00000002);
		wr(4'h2, 32'h0);
		wait_pin(0, 1'b1, 12000);
		@(posedge core_clk);
		hot_reset_in <= 1'b1;
		repeat (20) @(posedge core_clk);
		hot_reset_in <= 1'b0;
		wait_pin(0, 1'b0, 2);
		wait_pin(0, 1'b1, 12000);
		cmp(n >= `MIN_PULSE_CYC - 25, 1);
		wr(4'h1, 32'h00000001);
		fault <= 4'h1;
		wait_pin(0, 1'b0, 6);
		repeat (10100) @(posedge core_clk);
		cmp(pin[0], 1'b0);
		fault <= 4'h0;
		wait_pin(0, 1'b1, 60);
		cmp(n >= 14, 1);
		test_done;
	end
endmodule // port_reset_control_test
